// ===== verilog/adc_seq_defines.svh
// constants for the serial converter control sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// control byte field positions
`define CB_START        7
`define CB_SEL_HI       6
`define CB_SEL_LO       4
`define CB_UNIPOLAR     3
`define CB_SINGLE       2
`define CB_PD_HI        1
`define CB_PD_LO        0

// channel select codes {hi,mid,lo}
`define SEL_PAIR_A      3'h1
`define SEL_PAIR_B      3'h2
`define SEL_PAIR_A_REV  3'h5
`define SEL_PAIR_B_REV  3'h6

// software power modes
`define PWR_FULL_OFF    2'h0
`define PWR_QUICK_OFF   2'h1
`define PWR_REDUCED     2'h2
`define PWR_NORMAL      2'h3

// serial framing counts
`define BITS_TRACK      4'h5
`define BITS_BYTE       4'h8
`define POST_DEC_FIRST  5'h03
`define POST_DEC_LAST   5'h0E
`define POST_B6_DONE    5'h08
`define POST_END        5'h10
`define RESULT_MSB      4'hB

// timing
`define REF_CLK_NS      20
`define POR_TIME_NS     10000
`define POR_CYCLES      ((`POR_TIME_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define DROOP_TIME_NS   120000
`define DROOP_CYCLES    (`DROOP_TIME_NS / `REF_CLK_NS)

`endif

// ===== verilog/adc_seq_pkg.sv
// types shared by the converter sequencer files
package adc_seq_pkg;

  typedef logic [1:0] power_mode_t;
  typedef logic [3:0] channel_onehot_t;

  typedef enum logic [1:0] {
    RX_SEARCH,
    RX_BYTE,
    RX_DONE
  } rx_state_t;

endpackage : adc_seq_pkg

// ===== verilog/pin_sync.sv
// three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic ff1_r;
  logic ff2_r;
  logic ff3_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_r <= RESET_VAL;
      ff2_r <= RESET_VAL;
      ff3_r <= RESET_VAL;
    end else begin
      ff1_r <= pin;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // a change is taken only once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RESET_VAL;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= (ff2_r == ff3_r) && ff3_r && !level;
      fall <= (ff2_r == ff3_r) && !ff3_r && level;
      if (ff2_r == ff3_r) begin
        level <= ff3_r;
      end
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== verilog/adc_serial_control_sequencer.sv
// serial control, track/hold timing and sar sequencing of a 4-channel converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"

// Functional notes
// R1 - differential codes 001,010,101,110 pick CH0/CH1, CH2/CH3 and the reversed pairs
// R2 - sampler starts tracking on the sclk fall after the fifth control bit
// R3 - sampler holds on the sclk fall after the eighth control bit
// R4 - single-ended ties minus to common; after conversion plus input tracks again
// R5 - with chip select low one din bit is captured per sclk rise
// R6 - leading zeros are ignored; first one is the control byte msb
// R7 - conversion starts on the sclk fall after the eighth bit, not on select
// R8 - strobe is high for exactly one sclk period after the last control bit
// R9 - one decision per sclk, shown on dout at twelve rises, msb first
// R10 - dout and strobe float while select is high; strobe low after select falls
// R11 - unipolar result is straight binary, bipolar is two's complement, msb first
// R12 - result framed by three leading zeros and one trailing zero
// R13 - host lowers select, sends control byte, two zero bytes, raises select
// R14 - host is clock master, clock idles low, data sampled on rises
// R15 - host finishes hold to last result bit within 120 us
// R16 - start bit accepted when idle, or after result bit six is shifted out
// R17 - accepted conversion completes; only shutdown aborts it
// R18 - at most one conversion per 16 sclks; tied select needs 16 zeros first (code needs no leading zeros once reset is over)
// R19 - after power-on, normal mode, strobe low, 10 us internal reset
// R20 - before any conversion dout shifts out only zeros
// R21 - software power mode applies after conversion; shutdown overrides at once
// R22 - interface listens in power-down; start bit restores full power
// R23 - power bits: 00 full off, 01 quick off, 10 reduced, 11 normal
// R24 - byte: start, channel select, unipolar, single-ended, two power bits
// R25 - single-ended codes 001,101,010,110 select CH0,CH1,CH2,CH3
// R26 - shutdown input is active low and forces hardware power-down
module adc_serial_control_sequencer #(
  parameter int RESULT_BITS  = 12,
  parameter int DROOP_CYCLES = `DROOP_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      din,
  input  wire logic                      power_off_request_low,
  input  wire logic                      comparator_in,
  output logic                           dout,
  output logic                           dout_oe,
  output logic                           conversion_strobe_out,
  output logic                           conversion_strobe_oe,
  output logic                           sample_track,
  output adc_seq_pkg::channel_onehot_t   pos_channel,
  output adc_seq_pkg::channel_onehot_t   neg_channel,
  output logic                           neg_to_common,
  output logic                           polarity_choice,
  output logic                           input_topology_choice,
  output logic [RESULT_BITS-1:0]         dac_trial,
  output adc_seq_pkg::power_mode_t       power_mode,
  output logic                           hw_power_down,
  output logic                           reset_busy,
  output logic                           converting,
  output logic                           droop_warning
);
  import adc_seq_pkg::*;

  // synchronised pins
  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_lvl;
  logic cs_fall;
  logic din_lvl;
  logic power_off_request_low_lvl;

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (sclk),
    .level   (sclk_lvl),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (cs_n),
    .level   (cs_lvl),
    .rise    (),
    .fall    (cs_fall)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (din),
    .level   (din_lvl),
    .rise    (),
    .fall    ()
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_power_off_request_low (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (power_off_request_low),
    .level   (power_off_request_low_lvl),
    .rise    (),
    .fall    ()
  );

  localparam int POR_CNT_W   = $clog2(`POR_CYCLES + 1);
  localparam int DROOP_CNT_W = $clog2(DROOP_CYCLES + 1);

  rx_state_t                rx_state_r;
  logic [7:0]               shift_r;
  logic [3:0]               bit_cnt_r;
  logic [POR_CNT_W-1:0]     por_cnt_r;
  logic                     conv_active_r;
  logic [4:0]               post_cnt_r;
  logic [4:0]               post_nxt;
  logic [3:0]               dec_idx;
  logic                     dec_slot;
  logic                     search_ok;
  logic                     start_accept;
  logic                     byte_done;
  logic                     conv_done;
  logic                     power_off_request_low_active;
  power_mode_t              pending_pd_r;
  logic [DROOP_CNT_W-1:0]   droop_cnt_r;
  logic [2:0]               sel;
  logic [2:0]               sel_early;
  logic                     track_edge;

  assign power_off_request_low_active = !power_off_request_low_lvl; // [R26]
  assign post_nxt    = post_cnt_r + 5'h01;
  assign dec_slot    = (post_nxt >= `POST_DEC_FIRST) && (post_nxt <= `POST_DEC_LAST);
  assign dec_idx     = 4'(`POST_DEC_LAST - post_nxt);
  // overlap: a new byte may begin once result bit six has left
  assign search_ok   = !reset_busy && (!conv_active_r || post_cnt_r >= `POST_B6_DONE); // [R16] [R18] [R19]
  assign start_accept = sclk_rise && !cs_lvl && rx_state_r == RX_SEARCH && din_lvl && search_ok; // [R6]
  assign byte_done   = sclk_fall && rx_state_r == RX_DONE;
  assign conv_done   = sclk_rise && conv_active_r && post_nxt == `POST_END;
  assign sel         = shift_r[`CB_SEL_HI:`CB_SEL_LO];
  assign sel_early   = shift_r[3:1];
  assign track_edge  = sclk_fall && rx_state_r == RX_BYTE && bit_cnt_r == `BITS_TRACK;

  // internal power-on reset window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_r  <= '0;
      reset_busy <= 1'b1;
    end else if (reset_busy) begin
      if (por_cnt_r == POR_CNT_W'(`POR_CYCLES - 1)) begin // [R19]
        reset_busy <= 1'b0;
      end
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // control byte receiver
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= RX_SEARCH;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
    end else if (power_off_request_low_active) begin
      rx_state_r <= RX_SEARCH;
      bit_cnt_r  <= 4'h0;
    end else begin
      case (rx_state_r)
        RX_SEARCH: begin
          // zeros before the start bit are simply dropped
          if (start_accept) begin // [R6] [R22]
            shift_r    <= 8'h01;
            bit_cnt_r  <= 4'h1;
            rx_state_r <= RX_BYTE;
          end
        end
        RX_BYTE: begin
          if (sclk_rise && !cs_lvl) begin // [R5]
            shift_r   <= {shift_r[6:0], din_lvl};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == `BITS_BYTE - 4'h1) begin
              rx_state_r <= RX_DONE;
            end
          end
        end
        RX_DONE: begin
          if (sclk_fall) begin
            rx_state_r <= RX_SEARCH;
            bit_cnt_r  <= 4'h0;
          end
        end
        default: begin
          rx_state_r <= RX_SEARCH;
          bit_cnt_r  <= 4'h0;
        end
      endcase
    end
  end

  // track/hold and conversion stepping
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_track          <= 1'b1;
      conv_active_r         <= 1'b0;
      post_cnt_r            <= 5'h00;
      dac_trial             <= '0;
      dout                  <= 1'b0; // [R20]
    end else if (power_off_request_low_active) begin
      // shutdown stops the conversion where it stands
      conv_active_r <= 1'b0; // [R17] [R21]
      post_cnt_r    <= 5'h00;
      sample_track  <= 1'b1;
      dout          <= 1'b0;
    end else begin
      if (track_edge) begin
        sample_track <= 1'b1; // [R2]
      end
      if (conv_done) begin
        conv_active_r <= 1'b0;
        sample_track  <= 1'b1; // [R4]
        dout          <= 1'b0; // [R12]
      end else if (sclk_rise && conv_active_r) begin
        // each rise in the decision window (post_nxt 3 to 14) settles one bit and, before post_nxt 14, tries the next
        post_cnt_r <= post_nxt;
        if (dec_slot) begin
          dac_trial[dec_idx] <= comparator_in; // [R9]
          if (dec_idx != 4'h0) begin
            dac_trial[dec_idx - 4'h1] <= 1'b1;
          end
          // bipolar inverts only the msb to turn offset binary into two's complement
          dout <= (dec_idx == `RESULT_MSB && !polarity_choice) ? !comparator_in : comparator_in; // [R11]
        end else begin
          dout <= 1'b0; // [R12]
        end
      end
      if (byte_done) begin
        sample_track          <= 1'b0; // [R3]
        conv_active_r         <= 1'b1; // [R7]
        post_cnt_r            <= 5'h00;
        dac_trial             <= '0;
        dac_trial[RESULT_BITS-1] <= 1'b1;
      end
    end
  end

  // channel routing and mode bits latched from the control byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_channel           <= 4'h0;
      neg_channel           <= 4'h0;
      neg_to_common         <= 1'b1;
      polarity_choice       <= 1'b1;
      input_topology_choice <= 1'b1;
      pending_pd_r          <= `PWR_NORMAL;
    end else if (!power_off_request_low_active) begin
      if (track_edge) begin
        case (sel_early) // [R25] [R1]
          `SEL_PAIR_A:     pos_channel <= 4'h1;
          `SEL_PAIR_A_REV: pos_channel <= 4'h2;
          `SEL_PAIR_B:     pos_channel <= 4'h4;
          `SEL_PAIR_B_REV: pos_channel <= 4'h8;
          default:         pos_channel <= 4'h0;
        endcase
      end
      if (conv_done) begin
        // minus side returns to common once the result is out
        neg_to_common <= 1'b1; // [R4]
        neg_channel   <= 4'h0;
      end
      if (byte_done) begin
        polarity_choice       <= shift_r[`CB_UNIPOLAR]; // [R24]
        input_topology_choice <= shift_r[`CB_SINGLE];
        pending_pd_r          <= shift_r[`CB_PD_HI:`CB_PD_LO];
        if (shift_r[`CB_SINGLE]) begin
          neg_to_common <= 1'b1; // [R4]
          neg_channel   <= 4'h0;
        end else begin
          neg_to_common <= 1'b0;
          case (sel) // [R1]
            `SEL_PAIR_A:     neg_channel <= 4'h2;
            `SEL_PAIR_A_REV: neg_channel <= 4'h1;
            `SEL_PAIR_B:     neg_channel <= 4'h8;
            `SEL_PAIR_B_REV: neg_channel <= 4'h4;
            default:         neg_channel <= 4'h0;
          endcase
        end
      end
    end
  end

  // strobe and output enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_strobe_out <= 1'b0; // [R19]
      conversion_strobe_oe  <= 1'b0;
      dout_oe               <= 1'b0;
    end else begin
      conversion_strobe_oe <= !cs_lvl; // [R10]
      dout_oe              <= !cs_lvl;
      if (power_off_request_low_active || cs_fall) begin
        conversion_strobe_out <= 1'b0; // [R10]
      end else if (byte_done) begin
        conversion_strobe_out <= 1'b1; // [R8]
      end else if (sclk_fall) begin
        conversion_strobe_out <= 1'b0; // [R8]
      end
    end
  end

  // power state: full power from each start bit, and at each conversion end the mode chosen by that conversion's byte, unless a start bit is taken on the same rise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode    <= `PWR_NORMAL; // [R19]
      hw_power_down <= 1'b0;
    end else begin
      hw_power_down <= power_off_request_low_active; // [R26]
      if (start_accept) begin
        power_mode <= `PWR_NORMAL; // [R22]
      end else if (conv_done) begin
        power_mode <= pending_pd_r; // [R21] [R23]
      end
    end
  end

  // busy flag and droop watch from hold to the sixteenth sclk rise after it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      converting    <= 1'b0;
      droop_cnt_r   <= '0;
      droop_warning <= 1'b0;
    end else begin
      converting <= conv_active_r && !power_off_request_low_active;
      if (byte_done) begin
        droop_cnt_r   <= '0;
        droop_warning <= 1'b0;
      end else if (conv_active_r && droop_cnt_r != DROOP_CNT_W'(DROOP_CYCLES)) begin
        droop_cnt_r <= droop_cnt_r + 1'b1;
      end else if (conv_active_r) begin
        droop_warning <= 1'b1;
      end
    end
  end

endmodule : adc_serial_control_sequencer

`default_nettype wire

// ===== verif/adc_seq_monitor.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor #(
  parameter int RESULT_BITS = 12
) (
  input wire logic                          ref_clk,
  input wire logic                          rst_n,
  input wire logic                          cs_n,
  input wire logic                          power_off_request_low,
  input wire logic                          dout_oe,
  input wire logic                          conversion_strobe_out,
  input wire logic                          conversion_strobe_oe,
  input wire logic                          sample_track,
  input wire adc_seq_pkg::channel_onehot_t  neg_channel,
  input wire logic                          neg_to_common,
  input wire logic                          input_topology_choice,
  input wire logic [RESULT_BITS-1:0]        dac_trial,
  input wire adc_seq_pkg::power_mode_t      power_mode,
  input wire logic                          hw_power_down,
  input wire logic                          reset_busy,
  input wire logic                          converting
);
  import adc_seq_pkg::*;
  localparam logic [RESULT_BITS-1:0] MID = {1'b1, {(RESULT_BITS-1){1'b0}}};
  logic [9:0] busy_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_r <= 10'h000;
    else if (reset_busy) busy_cnt_r <= busy_cnt_r + 10'h001;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_oe_pair: assert property (dout_oe == conversion_strobe_oe)
    else $error("output enables differ");
  a_float_select: assert property (cs_n [*8] |-> !dout_oe)
    else $error("outputs driven while deselected");
  a_strobe_on_select: assert property ($rose(dout_oe) |-> !conversion_strobe_out)
    else $error("strobe not low after select");
  a_strobe_start: assert property ($rose(conversion_strobe_out) |-> (!sample_track && dac_trial == MID) ##1 $rose(converting))
    else $error("strobe not tied to hold and start");
  // bench serial clock period is eight system cycles
  a_strobe_width: assert property ($rose(conversion_strobe_out) |-> conversion_strobe_out [*8] ##1 !conversion_strobe_out)
    else $error("strobe width wrong");
  a_power_off_request_low_abort: assert property ($fell(power_off_request_low) |-> ##[1:8] (hw_power_down && !converting && !conversion_strobe_out))
    else $error("shutdown did not abort");
  a_power_off_request_low_level: assert property (power_off_request_low [*8] |-> !hw_power_down)
    else $error("power down without request");
  a_busy_length: assert property ($fell(reset_busy) |-> busy_cnt_r >= 10'd499 && busy_cnt_r <= 10'd501)
    else $error("internal reset length wrong");
  a_busy_idle: assert property (reset_busy |-> !converting && power_mode == 2'h3)
    else $error("activity during internal reset");
  a_minus_route: assert property (converting && !sample_track |-> neg_to_common == input_topology_choice)
    else $error("minus input routing wrong");
  a_mode_converting: assert property (converting && !sample_track |-> power_mode == 2'h3)
    else $error("low power during conversion");
  a_track_after: assert property ($fell(converting) && power_off_request_low |-> sample_track)
    else $error("no tracking after conversion");
endmodule : adc_seq_monitor

bind adc_serial_control_sequencer adc_seq_monitor #(.RESULT_BITS(RESULT_BITS)) u_adc_seq_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .power_off_request_low(power_off_request_low),
  .dout_oe(dout_oe), .conversion_strobe_out(conversion_strobe_out), .conversion_strobe_oe(conversion_strobe_oe),
  .sample_track(sample_track), .neg_channel(neg_channel), .neg_to_common(neg_to_common),
  .input_topology_choice(input_topology_choice), .dac_trial(dac_trial), .power_mode(power_mode),
  .hw_power_down(hw_power_down), .reset_busy(reset_busy), .converting(converting));
`default_nettype wire

// ===== verif/adc_host_model.sv
// host master model: mode 0 clock, select and byte transfers
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  input  wire logic        ref_clk,
  output logic             sclk,
  output logic             cs_n,
  output logic             din,
  input  wire logic        dout,
  input  wire logic        dout_oe,
  output logic             res_valid,
  output logic [15:0]      res_word
);
  logic line_r = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    res_valid = 1'b0;
    res_word = 16'h0000;
  end

  // clock stands low outside frames; released dout reads as inverse of last
  task automatic frame(input logic [7:0] ctrl, input int lead, input int nbytes);
    logic [15:0] rx;
    logic [31:0] tx;
    rx = 16'h0000;
    tx = {ctrl, 24'h000000};
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < lead + 8 * nbytes; i++) begin
      @(posedge ref_clk);
      din <= (i < lead) ? 1'b0 : tx[31 - (i - lead)];
      repeat (3) @(posedge ref_clk);
      sclk <= 1'b1;
      line_r = dout_oe ? dout : ~line_r;
      rx = {rx[14:0], line_r};
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    din <= ~din;
    if (nbytes == 3) begin
      res_word <= rx;
      res_valid <= 1'b1;
      @(posedge ref_clk);
      res_valid <= 1'b0;
    end
    repeat (16) @(posedge ref_clk);
  endtask : frame
endmodule : adc_host_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_seq_pkg::*;
  logic                 ref_clk, rst_n, power_off_request_low, comparator_in, sclk, cs_n, din;
  logic                 dout, dout_oe, conversion_strobe_out, conversion_strobe_oe, sample_track;
  logic                 neg_to_common, polarity_choice, input_topology_choice, hw_power_down;
  logic                 reset_busy, converting, droop_warning, res_valid;
  channel_onehot_t      pos_channel, neg_channel;
  power_mode_t          power_mode;
  logic [11:0]          dac_trial, target_r;
  logic [15:0]          res_word;
  logic [31:0]          seed_r;
  logic                 conv_d = 1'b0;
  logic [15:0]          cnotes[$], rnotes[$];
  logic [2:0]           codes[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  int                   miscompares, checks_done, cycles;

  always #10 ref_clk = ~ref_clk;

  adc_serial_control_sequencer #(.DROOP_CYCLES(200)) u_adc_serial_control_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .power_off_request_low(power_off_request_low), .comparator_in(comparator_in), .dout(dout),
    .dout_oe(dout_oe), .conversion_strobe_out(conversion_strobe_out), .conversion_strobe_oe(conversion_strobe_oe),
    .sample_track(sample_track), .pos_channel(pos_channel), .neg_channel(neg_channel),
    .neg_to_common(neg_to_common), .polarity_choice(polarity_choice), .input_topology_choice(input_topology_choice),
    .dac_trial(dac_trial), .power_mode(power_mode), .hw_power_down(hw_power_down), .reset_busy(reset_busy),
    .converting(converting), .droop_warning(droop_warning));

  adc_host_model u_adc_host_model (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .res_valid(res_valid), .res_word(res_word));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  function automatic logic [15:0] chan_note(input logic [2:0] code, input logic uni, input logic se);
    logic [7:0] pn;
    case (code)
      3'h1: pn = 8'h12;
      3'h5: pn = 8'h21;
      3'h2: pn = 8'h48;
      default: pn = 8'h84;
    endcase
    return {3'h0, pn[7:4], se ? 4'h0 : pn[3:0], se, uni, se, 2'h3};
  endfunction : chan_note

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : report

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp);
  endtask : check_word

  task automatic check_field(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp);
  endtask : check_field

  // sar stand-in: decision is input at or above the trial word
  always @(posedge ref_clk) comparator_in <= (dac_trial <= target_r);

  always @(posedge ref_clk) begin
    conv_d <= converting;
    if (converting === 1'b1 && conv_d === 1'b0 && cnotes.size() > 0)
      check_field({3'h0, pos_channel, neg_channel, neg_to_common, polarity_choice, input_topology_choice,
                   power_mode}, cnotes.pop_front());
    if (res_valid === 1'b1 && rnotes.size() > 0)
      check_word(res_word, rnotes.pop_front());
  end

  task automatic convert(input logic [2:0] code, input logic uni, input logic se, input logic [1:0] pd,
                         input logic [11:0] val, input int lead);
    target_r <= val;
    cnotes.push_back(chan_note(code, uni, se));
    rnotes.push_back({3'h0, uni ? val : val ^ 12'h800, 1'b0});
    u_adc_host_model.frame({1'b1, code, uni, se, pd}, lead, 3);
    repeat (8) @(posedge ref_clk);
    check_field({13'h0000, droop_warning, power_mode}, {13'h0000, 1'b0, pd});
  endtask : convert

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    power_off_request_low = 1'b1;
    target_r = 12'h000;
    seed_r = 32'd3833;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    u_adc_host_model.frame(8'hFF, 0, 1);
    for (int w = 0; w < 700 && reset_busy !== 1'b0; w++) @(posedge ref_clk);
    rnotes.push_back(16'h0000);
    u_adc_host_model.frame(8'h00, 2, 3);
    for (int i = 0; i < 16; i++) begin
      seed_r = xorshift(seed_r);
      convert(codes[i % 4], i[3], i[2], i[1:0] ^ i[3:2], seed_r[11:0], int'(seed_r[13:12]));
    end
    cnotes.push_back(chan_note(3'h1, 1'b1, 1'b1));
    u_adc_host_model.frame(8'h9F, 0, 2);
    repeat (160) @(posedge ref_clk);
    check_field({14'h0000, droop_warning, converting}, 16'h0003);
    power_off_request_low <= 1'b0;
    repeat (12) @(posedge ref_clk);
    check_field({14'h0000, hw_power_down, converting}, 16'h0002);
    power_off_request_low <= 1'b1;
    repeat (20) @(posedge ref_clk);
    convert(3'h6, 1'b0, 1'b0, 2'h3, 12'h7FF, 1);
    conclude();
  end
endmodule : tb
`default_nettype wire
